/* File: logic/rss_pkg.sv */
package rss_pkg;
    // strap window and fetch hold-off, in master clock cycles
    localparam int STRAP_WINDOW_CYCLES = 10;
    localparam int FETCH_DELAY_CYCLES = 80;
    localparam logic [6:0] FETCH_DELAY_COUNT = 7'(FETCH_DELAY_CYCLES);
    localparam logic [3:0] STRAP_WINDOW_COUNT = 4'(STRAP_WINDOW_CYCLES);
    // strap reset values: pull-up levels (8-bit boot, normal drive)
    localparam logic BOOT_WIDTH_RESET = 1'b1;
    localparam logic FLOAT_RESET = 1'b0;
    // pc reset value
    localparam logic [31:0] FETCH_RESET_ADDR = 32'h0000_0000;
    // boot width encodings
    localparam logic BOOT_WIDTH_8 = 1'b1;
    localparam logic BOOT_WIDTH_16 = 1'b0;
    // identification code, arbitrary value
    localparam logic [31:0] RSS_CHIP_ID = 32'h1234_5671;

    typedef enum logic [1:0] {
        RSS_IN_RESET,
        RSS_HOLD,
        RSS_RUN
    } rss_state_type;
endpackage

/* File: logic/rss_sync.sv */
`timescale 1ns/1ps
// two-stage level synchroniser, async set-to-zero
module rss_sync (
    // clock and async clear
    input wire logic mclk,
    input wire logic clr_n,
    // level in and out
    input wire logic d,
    output logic q
);
    logic [1:0] stage_reg;

    always_ff @(posedge mclk or negedge clr_n) begin
        if (!clr_n) begin
            stage_reg <= 2'h0;
        end else begin
            stage_reg <= {stage_reg[0], d};
        end
    end

    assign q = stage_reg[1];
endmodule // rss_sync

/* File: logic/rss_reset_sampler.sv */
`timescale 1ns/1ps
//
// Summary of operation
// - external reset is active low and enters reset without a clock edge
// - reset release is synchronised to the master clock
// - first fetch held off until 80 cycles after synchronised reset release
// - any reset clears peripheral registers and points fetch at zero
// - watchdog reset acts like external reset but keeps straps
// - external reset wins over a simultaneous watchdog reset
// - float strap low for last ten cycles enters tri-state mode
// - tri-state mode disables every output pad driver
// - tri-state mode leaves flash reachable from the pins
// - float strap shares pin with io line 21 and serial 1 transmit
// - clock image driven on clock out pin until reprogrammed
// - all peripheral io pins are inputs after reset
// - debug port answers identification with a non-standard chip id
// - boot width taken from strap over last ten cycles before release
// - strap 1 selects 8-bit boot, 0 selects 16-bit boot
// - boot width strap doubles as io line 24 after reset
// - remap state cleared only by internal or external reset
module rss_reset_sampler
    import rss_pkg::*;
#(
    parameter int FETCH_DELAY = FETCH_DELAY_CYCLES,
    parameter int STRAP_WINDOW = STRAP_WINDOW_CYCLES
) (
    // clock and resets
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic watchdog_reset,
    // shared strap pins (strap during reset only)
    input wire logic io_line_24_in,
    input wire logic io_line_21_in,
    // software controls from peripheral logic
    input wire logic remap_request,
    input wire logic clock_out_as_io,
    input wire logic io_line_24_out,
    input wire logic io_line_21_out,
    input wire logic serial1_transmit,
    input wire logic serial1_enable,
    input wire logic [31:0] pad_out_in,
    input wire logic [31:0] pad_drive_in,
    input wire logic debug_id_request,
    // core side
    output logic core_reset_n,
    output logic periph_reset_n,
    output logic fetch_enable,
    output logic [31:0] fetch_addr,
    output logic boot_width_strap,
    output logic float_mode,
    output logic remap_active,
    output logic flash_pin_access,
    output logic [31:0] debug_id,
    // pads: output enables are low while driving
    output logic master_clock_out_pin,
    output logic clock_out_oe_n,
    output logic io_line_24_o,
    output logic io_line_24_oe_n,
    output logic io_line_21_o,
    output logic io_line_21_oe_n,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe_n
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        rss_state_type state;
        logic [6:0] delay_cnt;
        logic [3:0] bw_low_cnt;
        logic [3:0] bw_high_cnt;
        logic [3:0] float_low_cnt;
        logic boot_width;
        logic float_mode;
        logic remap;
        logic ext_seen;
        logic [31:0] debug_id;
    } rss_regs_type;

    rss_regs_type s_reg;
    rss_regs_type s_next;
    logic ext_released;
    logic any_reset;
    logic wd_only;
    logic strap_take;

    ////////////////////////////////////////////////////////////////////////
    // async assert, sync release of the pin
    rss_sync rss_sync_i (
        .mclk(mclk),
        .clr_n(ext_reset_n),
        .d(1'b1),
        .q(ext_released)
    );

    // count saturation helper used by all strap window counters
    function automatic logic [3:0] rss_sat_inc(input logic [3:0] c, input logic hit);
        logic [3:0] r;
        r = 4'h0;
        if (hit) begin
            r = (c == 4'hF) ? c : 4'(c + 4'h1);
        end
        return r;
    endfunction

    assign wd_only = watchdog_reset && ext_released;
    assign any_reset = !ext_released || watchdog_reset;
    // the one edge at which straps are taken
    assign strap_take = (s_reg.state == RSS_IN_RESET) && s_reg.ext_seen && ext_released
                        && !watchdog_reset;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.debug_id = debug_id_request ? RSS_CHIP_ID : s_reg.debug_id;
        if (!ext_released) begin
            // straps track the pin levels; only the last cycles matter
            s_next.state = RSS_IN_RESET;
            s_next.bw_low_cnt = rss_sat_inc(s_reg.bw_low_cnt, !io_line_24_in);
            s_next.bw_high_cnt = rss_sat_inc(s_reg.bw_high_cnt, io_line_24_in);
            s_next.float_low_cnt = rss_sat_inc(s_reg.float_low_cnt, !io_line_21_in);
            s_next.ext_seen = 1'b1;
            s_next.remap = 1'b0;
            s_next.delay_cnt = 7'h00;
        end else if (wd_only) begin
            // straps kept as they were
            s_next.state = RSS_HOLD;
            s_next.remap = 1'b0;
            s_next.delay_cnt = 7'h00;
            s_next.ext_seen = 1'b0;
        end else begin
            unique case (s_reg.state)
                RSS_IN_RESET: begin
                    if (s_reg.ext_seen) begin
                        // latch straps on first synchronised cycle out of reset
                        s_next.float_mode = s_reg.float_low_cnt >= 4'(STRAP_WINDOW);
                        if (s_reg.bw_high_cnt >= 4'(STRAP_WINDOW)) begin
                            s_next.boot_width = BOOT_WIDTH_8;
                        end else if (s_reg.bw_low_cnt >= 4'(STRAP_WINDOW)) begin
                            s_next.boot_width = BOOT_WIDTH_16;
                        end
                    end
                    s_next.ext_seen = 1'b0;
                    // fresh window, so a short later press never reuses old counts
                    s_next.bw_low_cnt = 4'h0;
                    s_next.bw_high_cnt = 4'h0;
                    s_next.float_low_cnt = 4'h0;
                    s_next.delay_cnt = 7'h01;
                    s_next.state = RSS_HOLD;
                end
                RSS_HOLD: begin
                    s_next.delay_cnt = 7'(s_reg.delay_cnt + 7'h01);
                    if (s_reg.delay_cnt >= 7'(FETCH_DELAY - 1)) begin
                        s_next.state = RSS_RUN;
                    end
                end
                RSS_RUN: begin
                    if (remap_request) begin
                        s_next.remap = 1'b1;
                    end
                end
                default: s_next.state = RSS_IN_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_reg <= '{state: RSS_IN_RESET, delay_cnt: 7'h00, bw_low_cnt: 4'h0,
                       bw_high_cnt: 4'h0, float_low_cnt: 4'h0,
                       boot_width: BOOT_WIDTH_RESET, float_mode: FLOAT_RESET,
                       remap: 1'b0, ext_seen: 1'b0, debug_id: 32'h0000_0000};
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // resets for core and peripherals
    assign core_reset_n = !any_reset && (s_reg.state != RSS_IN_RESET);
    assign periph_reset_n = core_reset_n;
    assign fetch_enable = (s_reg.state == RSS_RUN) && !any_reset;
    assign fetch_addr = FETCH_RESET_ADDR;
    assign boot_width_strap = s_reg.boot_width;
    assign float_mode = s_reg.float_mode;
    assign remap_active = s_reg.remap;
    assign flash_pin_access = s_reg.float_mode;
    assign debug_id = s_reg.debug_id;

    // pads; float mode overrides every driver
    always_comb begin
        master_clock_out_pin = mclk;
        clock_out_oe_n = s_reg.float_mode || (clock_out_as_io && core_reset_n);
        io_line_24_o = io_line_24_out;
        io_line_21_o = serial1_enable ? serial1_transmit : io_line_21_out;
        // lines stay inputs in reset and float mode, and until software drives them
        io_line_24_oe_n = !core_reset_n || s_reg.float_mode
                          || !pad_drive_in[24];
        io_line_21_oe_n = !core_reset_n || s_reg.float_mode || !(serial1_enable
                          || pad_drive_in[21]);
        pad_out = pad_out_in;
        pad_oe_n = (!core_reset_n || s_reg.float_mode) ? 32'hFFFF_FFFF : ~pad_drive_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // checking aid: cycles since any reset was last seen, saturating
    logic [7:0] quiet_cnt_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n || any_reset) begin
            quiet_cnt_reg <= 8'h00;
        end else if (quiet_cnt_reg != 8'hFF) begin
            quiet_cnt_reg <= 8'(quiet_cnt_reg + 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_FLOAT_PADS: assert property (@(posedge mclk) disable iff (!rst_n)
        s_reg.float_mode |-> (pad_oe_n == 32'hFFFF_FFFF) && clock_out_oe_n)
        else $error("pads driven in float mode");
    AST_FETCH_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(ext_released) && !watchdog_reset |-> !fetch_enable [*8])
        else $error("fetch too early after release");
    AST_WD_KEEPS_STRAPS: assert property (@(posedge mclk) disable iff (!rst_n)
        wd_only |=> $stable(s_reg.boot_width) && $stable(s_reg.float_mode))
        else $error("straps changed on watchdog reset");
    AST_REMAP_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
        any_reset |=> !s_reg.remap)
        else $error("remap survived reset");
    AST_IO_INPUTS: assert property (@(posedge mclk) disable iff (!rst_n)
        !core_reset_n |-> io_line_24_oe_n && (pad_oe_n == 32'hFFFF_FFFF))
        else $error("pad driven during reset");
    AST_EXT_PRIORITY: assert property (@(posedge mclk) disable iff (!rst_n)
        !ext_released && watchdog_reset |=> s_reg.state == RSS_IN_RESET)
        else $error("watchdog overrode external reset");
    AST_FETCH_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(fetch_enable) |-> fetch_addr == FETCH_RESET_ADDR)
        else $error("fetch not from zero");
    AST_BOOT_SAMPLE: assert property (@(posedge mclk) disable iff (!rst_n)
        strap_take && (s_reg.bw_high_cnt >= 4'(STRAP_WINDOW))
        |=> boot_width_strap == BOOT_WIDTH_8)
        else $error("boot width not sampled");
    AST_ASYNC_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
        !ext_reset_n |-> !ext_released && !core_reset_n && !periph_reset_n)
        else $error("pin reset did not hold the core");
    AST_SYNC_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(ext_released) |-> ext_reset_n && $past(ext_reset_n))
        else $error("release not clocked through");
    AST_TWO_STAGE: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(ext_released) |-> $past(ext_reset_n, 2))
        else $error("release skipped a synchroniser stage");
    AST_CORE_AFTER_SYNC: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(core_reset_n) |-> $past(ext_released))
        else $error("core left reset before synchronised release");
    AST_FETCH_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(fetch_enable) |-> quiet_cnt_reg == 8'(FETCH_DELAY))
        else $error("fetch hold-off length wrong");
    AST_NO_EARLY_FETCH: assert property (@(posedge mclk) disable iff (!rst_n)
        fetch_enable |-> quiet_cnt_reg >= 8'(FETCH_DELAY))
        else $error("fetch allowed inside hold-off");
    AST_RESET_PERIPH: assert property (@(posedge mclk) disable iff (!rst_n)
        any_reset |-> !core_reset_n && !periph_reset_n && !fetch_enable)
        else $error("reset not passed to core and peripherals");
    AST_WD_ACTS: assert property (@(posedge mclk) disable iff (!rst_n)
        wd_only |=> (s_reg.state == RSS_HOLD) && (s_reg.delay_cnt == 7'h00))
        else $error("watchdog reset did not restart hold-off");
    AST_EXT_WINS: assert property (@(posedge mclk) disable iff (!rst_n)
        !ext_released && watchdog_reset |=> s_reg.ext_seen)
        else $error("watchdog hid the external reset");
    AST_FLOAT_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
        strap_take && (s_reg.float_low_cnt >= 4'(STRAP_WINDOW)) |=> float_mode)
        else $error("float mode not entered");
    AST_FLOAT_NORMAL: assert property (@(posedge mclk) disable iff (!rst_n)
        strap_take && (s_reg.float_low_cnt < 4'(STRAP_WINDOW)) |=> !float_mode)
        else $error("float mode entered without strap");
    AST_FLOAT_LINES: assert property (@(posedge mclk) disable iff (!rst_n)
        float_mode |-> io_line_24_oe_n && io_line_21_oe_n)
        else $error("io line driven in float mode");
    AST_FLASH_OPEN: assert property (@(posedge mclk) disable iff (!rst_n)
        float_mode |-> flash_pin_access)
        else $error("flash not reachable in float mode");
    AST_LINE21_SERIAL: assert property (@(posedge mclk) disable iff (!rst_n)
        core_reset_n && !float_mode && serial1_enable
        |-> !io_line_21_oe_n && (io_line_21_o == serial1_transmit))
        else $error("serial transmit not on line 21");
    AST_CLOCK_IMAGE: assert property (@(posedge mclk) disable iff (!rst_n)
        !float_mode && !(clock_out_as_io && core_reset_n)
        |-> !clock_out_oe_n && (master_clock_out_pin == mclk))
        else $error("clock image not driven");
    AST_IO21_INPUT: assert property (@(posedge mclk) disable iff (!rst_n)
        !core_reset_n |-> io_line_21_oe_n)
        else $error("line 21 driven during reset");
    AST_DEBUG_ID: assert property (@(posedge mclk) disable iff (!rst_n)
        debug_id_request |=> debug_id == RSS_CHIP_ID)
        else $error("chip id not answered");
    AST_BOOT_16: assert property (@(posedge mclk) disable iff (!rst_n)
        strap_take && (s_reg.bw_low_cnt >= 4'(STRAP_WINDOW))
        |=> boot_width_strap == BOOT_WIDTH_16)
        else $error("16-bit boot not sampled");
    AST_LINE24_IO: assert property (@(posedge mclk) disable iff (!rst_n)
        core_reset_n && !float_mode && pad_drive_in[24]
        |-> !io_line_24_oe_n && (io_line_24_o == io_line_24_out))
        else $error("line 24 not usable as io");
    AST_REMAP_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        s_reg.remap && !any_reset |=> remap_active)
        else $error("remap lost without reset");
    AST_STRAP_EXT_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
        !strap_take |=> $stable(boot_width_strap) && $stable(float_mode))
        else $error("straps changed outside external release");
endmodule // rss_reset_sampler

/* File: testbench/rss_board_model.sv */
`timescale 1ns/1ps
module rss_board_model (
    // clock from the bench
    input wire logic mclk,
    // reset button and strap resistors
    output logic ext_reset_n,
    output logic io_line_24_in,
    output logic io_line_21_in
);
    // power-on: button held, float strap pulled up
    initial begin
        ext_reset_n = 1'b0;
        io_line_24_in = 1'b1;
        io_line_21_in = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic press_reset(input logic boot_lvl, input logic float_n_lvl, input int hold);
        @(posedge mclk);
        ext_reset_n <= 1'b0;
        io_line_24_in <= boot_lvl;
        io_line_21_in <= float_n_lvl;
        repeat (hold) @(posedge mclk);
        ext_reset_n <= 1'b1;
        // straps kept past the synchronised window, then let go
        repeat (4) @(posedge mclk);
        io_line_24_in <= ~boot_lvl;
        io_line_21_in <= 1'b1;
    endtask
    task automatic set_pins(input logic boot_lvl, input logic float_n_lvl);
        @(posedge mclk);
        io_line_24_in <= boot_lvl;
        io_line_21_in <= float_n_lvl;
    endtask
endmodule // rss_board_model

/* File: testbench/rss_reset_sampler_bench.sv */
`timescale 1ns/1ps
module rss_reset_sampler_bench;
    import rss_pkg::*;
    logic mclk = 1'b0;
    logic rst_n, watchdog_reset, remap_request, debug_id_request, clock_out_as_io;
    logic io_line_24_out, io_line_21_out, serial1_transmit, serial1_enable;
    logic io_line_24_o, io_line_24_oe_n, io_line_21_o, io_line_21_oe_n;
    logic [31:0] pad_out_in, pad_drive_in, fetch_addr, debug_id, pad_oe_n, pad_out;
    logic ext_reset_n, io_line_24_in, io_line_21_in, core_reset_n, periph_reset_n;
    logic fetch_enable, boot_width_strap, float_mode, remap_active, flash_pin_access;
    logic master_clock_out_pin, clock_out_oe_n;
    int num_errors = 0;
    int cmp_count = 0;
    always #10 mclk = ~mclk;
    rss_board_model rss_board_model_i (.mclk(mclk), .ext_reset_n(ext_reset_n),
        .io_line_24_in(io_line_24_in), .io_line_21_in(io_line_21_in));
    rss_reset_sampler rss_reset_sampler_i (.mclk(mclk), .rst_n(rst_n),
        .ext_reset_n(ext_reset_n), .watchdog_reset(watchdog_reset),
        .io_line_24_in(io_line_24_in), .io_line_21_in(io_line_21_in),
        .remap_request(remap_request), .clock_out_as_io(clock_out_as_io),
        .io_line_24_out(io_line_24_out), .io_line_21_out(io_line_21_out),
        .serial1_transmit(serial1_transmit), .serial1_enable(serial1_enable),
        .pad_out_in(pad_out_in), .pad_drive_in(pad_drive_in),
        .debug_id_request(debug_id_request), .core_reset_n(core_reset_n),
        .periph_reset_n(periph_reset_n), .fetch_enable(fetch_enable),
        .fetch_addr(fetch_addr), .boot_width_strap(boot_width_strap),
        .float_mode(float_mode), .remap_active(remap_active),
        .flash_pin_access(flash_pin_access), .debug_id(debug_id),
        .master_clock_out_pin(master_clock_out_pin), .clock_out_oe_n(clock_out_oe_n),
        .io_line_24_o(io_line_24_o), .io_line_24_oe_n(io_line_24_oe_n),
        .io_line_21_o(io_line_21_o), .io_line_21_oe_n(io_line_21_oe_n),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // bounded wait; n counts edges already spent by the caller
    task automatic wait_fetch(input int n, input int lo, input int hi);
        while (fetch_enable !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("fetch_delay_in_range", 32'(n >= lo && n <= hi), 1);
    endtask
    task automatic boot_run(input logic b, input logic f);
        pad_drive_in <= 32'h0000_0000;
        fork
            rss_board_model_i.press_reset(b, f, 12);
            begin
                @(posedge mclk);
                #1;
                check("core_reset_n", core_reset_n, 0);
                check("periph_reset_n", periph_reset_n, 0);
                check("clock_image", master_clock_out_pin, mclk);
            end
        join
        wait_fetch(4, 81, 84);
        check("fetch_addr", fetch_addr, FETCH_RESET_ADDR);
        check("boot_width", boot_width_strap, b);
        check("float_mode", float_mode, !f);
        check("flash_access", flash_pin_access, !f);
        check("clock_oe_n", clock_out_oe_n, !f);
        check("pads_inputs", pad_oe_n, 32'hFFFF_FFFF);
        check("io24_inputs", io_line_24_oe_n, 1);
        pad_drive_in <= 32'hFFFF_FFFF;
        @(posedge mclk);
        #1;
        check("pads_drive", pad_oe_n, f ? 32'h0000_0000 : 32'hFFFF_FFFF);
        $display("boot run boot=%0b float_n=%0b done", b, f);
    endtask
    task automatic watchdog_run();
        @(posedge mclk);
        remap_request <= 1'b1;
        @(posedge mclk);
        remap_request <= 1'b0;
        repeat (2) @(posedge mclk);
        check("remap_set", remap_active, 1);
        // straps opposite to the latched ones; a watchdog must not take them
        rss_board_model_i.set_pins(1'b0, 1'b0);
        watchdog_reset <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("wd_core_reset", core_reset_n, 0);
        @(posedge mclk);
        watchdog_reset <= 1'b0;
        wait_fetch(0, 80, 80);
        check("wd_remap", remap_active, 0);
        check("wd_boot_kept", boot_width_strap, BOOT_WIDTH_8);
        check("wd_float_kept", float_mode, 0);
        $display("watchdog run done");
    endtask
    task automatic io_run();
        @(posedge mclk);
        pad_drive_in <= 32'h0100_0000;
        io_line_24_out <= 1'b1;
        serial1_enable <= 1'b1;
        serial1_transmit <= 1'b1;
        clock_out_as_io <= 1'b1;
        @(posedge mclk);
        #1;
        check("io24_oe_n", io_line_24_oe_n, 0);
        check("io24_data", io_line_24_o, 1);
        check("io21_oe_n", io_line_21_oe_n, 0);
        check("io21_serial", io_line_21_o, 1);
        check("clock_as_io", clock_out_oe_n, 1);
        check("pad_out", pad_out, 32'hA5A5_5A5A);
        serial1_enable <= 1'b0;
        pad_drive_in <= 32'h0000_0000;
        @(posedge mclk);
        #1;
        check("io21_released", io_line_21_oe_n, 1);
        check("io21_plain", io_line_21_o, 0);
        check("io24_released", io_line_24_oe_n, 1);
        clock_out_as_io <= 1'b0;
        $display("io run done");
    endtask
    task automatic both_run();
        fork
            rss_board_model_i.press_reset(1'b0, 1'b0, 12);
            begin
                repeat (3) @(posedge mclk);
                watchdog_reset <= 1'b1;
                repeat (4) @(posedge mclk);
                watchdog_reset <= 1'b0;
            end
        join
        wait_fetch(4, 81, 84);
        check("both_boot", boot_width_strap, BOOT_WIDTH_16);
        check("both_float", float_mode, 1);
        $display("combined reset run done");
    endtask
    task automatic debug_run();
        check("debug_id_idle", debug_id, 0);
        @(posedge mclk);
        debug_id_request <= 1'b1;
        @(posedge mclk);
        #1;
        check("debug_id", debug_id, RSS_CHIP_ID);
        debug_id_request <= 1'b0;
        $display("debug id run done");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        watchdog_reset = 1'b0;
        remap_request = 1'b0;
        debug_id_request = 1'b0;
        clock_out_as_io = 1'b0;
        io_line_24_out = 1'b0;
        io_line_21_out = 1'b0;
        serial1_transmit = 1'b0;
        serial1_enable = 1'b0;
        pad_out_in = 32'hA5A5_5A5A;
        pad_drive_in = 32'h0000_0000;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            boot_run(i[1], i[0]);
        end
        watchdog_run();
        io_run();
        both_run();
        debug_run();
        wrap_up();
    end
    // about 580 cycles expected; cut a hang well beyond that
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
endmodule // rss_reset_sampler_bench
